// File: logic/crbb_pkg.sv
// Purpose: Shared constants for the register bridge and bank
// Assumes: 32-bit data, byte addresses on the processor bus
// Notes:   Offsets are byte addresses; word indices derive from them
package crbb_pkg;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int ADDR_W = 12;
  localparam int IDX_W  = ADDR_W - 2;

  // ******************************************************
  // Register offsets
  // ******************************************************
  localparam logic [ADDR_W-1:0] OFS_FILE_INDEX = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_FILE_COUNT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SIZE_CODE  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_TIMESTAMP  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_COMMAND    = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_PATTERN    = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 12'h100;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int FILE_IDX_MSB = 15;
  localparam int FILE_CNT_MSB = 15;
  localparam int SIZE_MSB     = 2;
  localparam int CMD_MSB      = 1;
  localparam int PATT_MSB     = 2;
  localparam int SEC_LSB      = 0;
  localparam int SEC_MSB      = 4;
  localparam int MIN_LSB      = 5;
  localparam int MIN_MSB      = 10;
  localparam int HOUR_LSB     = 11;
  localparam int HOUR_MSB     = 15;
  localparam int DAY_LSB      = 16;
  localparam int DAY_MSB      = 20;
  localparam int MON_LSB      = 21;
  localparam int MON_MSB      = 24;
  localparam int YEAR_LSB     = 25;
  localparam int YEAR_MSB     = 31;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_ERR_BIT   = 1;
  localparam int ST_FAIL_BIT  = 2;

  // ******************************************************
  // Reset values and bus answers
  // ******************************************************
  localparam logic [DATA_W-1:0] RST_WORD  = 32'h0000_0000;
  localparam logic [1:0]        RESP_OKAY = 2'h0;
  localparam int                RD_LAT    = 2;

  typedef enum logic [2:0] {
    CRBB_PATT_INC  = 3'h0,
    CRBB_PATT_DEC  = 3'h1,
    CRBB_PATT_ZERO = 3'h2,
    CRBB_PATT_ONES = 3'h3,
    CRBB_PATT_LFSR = 3'h4
  } crbb_patt_t;
endpackage

// File: logic/crbb_register_subsystem.sv
// Purpose: AXI4-Lite to register bridge with clock crossing, plus register bank
// Assumes: One access in flight; engine status signals run on the fabric clock
// Notes:   Byte lanes are carried to the bank but the bank ignores them
// Operation
// - Bridge turns AXI4-Lite accesses into register accesses
// - Bank runs entirely on the fabric clock
// - Write strobe one cycle with index, value, lanes
// - Register index counts 32-bit words
// - Lane bit n qualifies value byte n
// - Read request, wait read-valid, capture value
// - Index held from read request until valid
// - Strobe or request decodes the word index
// - Writes load whole value, lanes ignored
// - Read data through mux and pipeline register
// - Read-valid is request delayed two flops
// - Offset 0x00 bits 15:0 drive file index
// - Offset 0x04 bits 15:0 drive file count
// - Offset 0x08 bits 2:0 drive size code
// - Offset 0x0C holds timestamp fields
// - Command write sets code and issues request
// - Offset 0x14 bits 2:0 select pattern
// - Status offset 0x100 gives busy, error
// - Status bit 2 reports verification failure
`timescale 1ns/1ns
module crbb_register_subsystem (
  input  wire logic                          processor_clock, // AXI side clock
  input  wire logic                          clock,           // Fabric clock
  input  wire logic                          nrst,            // Async reset, active low
  input  wire logic [crbb_pkg::ADDR_W-1:0]   s_axi_awaddr,    // Write address
  input  wire logic                          s_axi_awvalid,   // Write address valid
  output logic                               s_axi_awready,   // Write address ready
  input  wire logic [crbb_pkg::DATA_W-1:0]   s_axi_wdata,     // Write data
  input  wire logic [crbb_pkg::STRB_W-1:0]   s_axi_wstrb,     // Write strobes
  input  wire logic                          s_axi_wvalid,    // Write data valid
  output logic                               s_axi_wready,    // Write data ready
  output logic [1:0]                         s_axi_bresp,     // Write response
  output logic                               s_axi_bvalid,    // Write response valid
  input  wire logic                          s_axi_bready,    // Write response ready
  input  wire logic [crbb_pkg::ADDR_W-1:0]   s_axi_araddr,    // Read address
  input  wire logic                          s_axi_arvalid,   // Read address valid
  output logic                               s_axi_arready,   // Read address ready
  output logic [crbb_pkg::DATA_W-1:0]        s_axi_rdata,     // Read data
  output logic [1:0]                         s_axi_rresp,     // Read response
  output logic                               s_axi_rvalid,    // Read data valid
  input  wire logic                          s_axi_rready,    // Read data ready
  output logic [crbb_pkg::FILE_IDX_MSB:0]    target_file_index, // File engine index
  output logic [crbb_pkg::FILE_CNT_MSB:0]    file_count,      // File engine count
  output logic [crbb_pkg::SIZE_MSB:0]        file_size_code,  // File engine size code
  output logic [4:0]                         stamp_seconds,   // Timestamp seconds
  output logic [5:0]                         stamp_minutes,   // Timestamp minutes
  output logic [4:0]                         stamp_hours,     // Timestamp hours
  output logic [4:0]                         stamp_day,       // Timestamp day
  output logic [3:0]                         stamp_month,     // Timestamp month
  output logic [6:0]                         stamp_year,      // Timestamp year
  output logic [crbb_pkg::CMD_MSB:0]         command_code,    // Engine command
  output logic                               command_request, // One-cycle start pulse
  output logic [crbb_pkg::PATT_MSB:0]        pattern_select,  // Pattern generator mode
  input  wire logic                          engine_busy,     // Engine busy flag
  input  wire logic                          engine_error,    // Engine error flag
  input  wire logic                          verify_fail      // Pattern check failed
);
  import crbb_pkg::*;

  typedef enum logic [1:0] {PS_IDLE, PS_WAIT, PS_BRESP, PS_RRESP} crbb_pstate_t;
  typedef enum logic {FS_IDLE, FS_READ_WAIT} crbb_fstate_t;

  localparam logic [IDX_W-1:0] IDX_FILE_INDEX = OFS_FILE_INDEX[ADDR_W-1:2];
  localparam logic [IDX_W-1:0] IDX_FILE_COUNT = OFS_FILE_COUNT[ADDR_W-1:2];
  localparam logic [IDX_W-1:0] IDX_SIZE_CODE  = OFS_SIZE_CODE[ADDR_W-1:2];
  localparam logic [IDX_W-1:0] IDX_TIMESTAMP  = OFS_TIMESTAMP[ADDR_W-1:2];
  localparam logic [IDX_W-1:0] IDX_COMMAND    = OFS_COMMAND[ADDR_W-1:2];
  localparam logic [IDX_W-1:0] IDX_PATTERN    = OFS_PATTERN[ADDR_W-1:2];
  localparam logic [IDX_W-1:0] IDX_STATUS     = OFS_STATUS[ADDR_W-1:2];

  // Processor domain
  crbb_pstate_t             ps_r;
  logic                     p_req_tgl_r;
  logic                     p_is_write_r;
  logic [IDX_W-1:0]         p_index_r;
  logic [DATA_W-1:0]        p_value_r;
  logic [STRB_W-1:0]        p_lanes_r;
  logic                     p_ack_s1_r;
  logic                     p_ack_s2_r;
  logic                     p_ack_seen_r;
  logic [DATA_W-1:0]        p_rdata_r;
  logic                     take_write;
  logic                     take_read;
  logic                     ack_arrived;

  // Fabric domain
  crbb_fstate_t             fs_r;
  logic                     f_req_s1_r;
  logic                     f_req_s2_r;
  logic                     f_req_seen_r;
  logic                     f_ack_tgl_r;
  logic [DATA_W-1:0]        f_rdata_r;
  logic                     new_request;
  logic                     reg_write_strobe;
  logic                     reg_read_request;
  logic                     reg_read_valid;
  logic [IDX_W-1:0]         reg_word_index;
  logic [DATA_W-1:0]        reg_write_value;
  logic [STRB_W-1:0]        reg_byte_lanes;
  logic [DATA_W-1:0]        reg_read_value;
  logic                     rd_dly_r;
  logic                     rd_valid_r;
  logic [DATA_W-1:0]        rd_mux;
  logic [DATA_W-1:0]        rd_pipe_r;
  logic [DATA_W-1:0]        file_index_reg_r;
  logic [DATA_W-1:0]        file_count_reg_r;
  logic [DATA_W-1:0]        file_size_code_reg_r;
  logic [DATA_W-1:0]        file_timestamp_reg_r;
  logic [DATA_W-1:0]        command_reg_r;
  logic [DATA_W-1:0]        pattern_choice_reg_r;
  logic                     cmd_req_r;
  logic [DATA_W-1:0]        status_word;

  // ******************************************************
  // AXI4-Lite slave, processor clock
  // ******************************************************
  // write wins over read
  assign take_write    = (ps_r == PS_IDLE) && s_axi_awvalid && s_axi_wvalid;
  assign take_read     = (ps_r == PS_IDLE) && s_axi_arvalid && !take_write;
  assign s_axi_awready = take_write;
  assign s_axi_wready  = take_write;
  assign s_axi_arready = take_read;
  assign s_axi_bresp   = RESP_OKAY;
  assign s_axi_rresp   = RESP_OKAY;
  assign s_axi_bvalid  = (ps_r == PS_BRESP);
  assign s_axi_rvalid  = (ps_r == PS_RRESP);
  assign s_axi_rdata   = p_rdata_r;
  assign ack_arrived   = (p_ack_s2_r != p_ack_seen_r);

  always_ff @(posedge processor_clock or negedge nrst) begin
    if (!nrst) begin
      ps_r <= PS_IDLE;
    end else begin
      unique case (ps_r)
        PS_IDLE: begin
          if (take_write || take_read) begin
            ps_r <= PS_WAIT;
          end
        end
        PS_WAIT: begin
          if (ack_arrived) begin
            ps_r <= p_is_write_r ? PS_BRESP : PS_RRESP;
          end
        end
        PS_BRESP: begin
          if (s_axi_bready) begin
            ps_r <= PS_IDLE;
          end
        end
        PS_RRESP: begin
          if (s_axi_rready) begin
            ps_r <= PS_IDLE;
          end
        end
      endcase
    end
  end

  // Request fields stay frozen until the ack returns, so the fabric
  // side may sample them as a bundle once the toggle is synchronised
  always_ff @(posedge processor_clock or negedge nrst) begin
    if (!nrst) begin
      p_req_tgl_r  <= 1'b0;
      p_is_write_r <= 1'b0;
      p_index_r    <= '0;
      p_value_r    <= RST_WORD;
      p_lanes_r    <= '0;
    end else if (take_write) begin
      p_req_tgl_r  <= ~p_req_tgl_r;
      p_is_write_r <= 1'b1;
      p_index_r    <= s_axi_awaddr[ADDR_W-1:2];
      p_value_r    <= s_axi_wdata;
      p_lanes_r    <= s_axi_wstrb;
    end else if (take_read) begin
      p_req_tgl_r  <= ~p_req_tgl_r;
      p_is_write_r <= 1'b0;
      p_index_r    <= s_axi_araddr[ADDR_W-1:2];
    end
  end

  always_ff @(posedge processor_clock or negedge nrst) begin
    if (!nrst) begin
      p_ack_s1_r   <= 1'b0;
      p_ack_s2_r   <= 1'b0;
      p_ack_seen_r <= 1'b0;
      p_rdata_r    <= RST_WORD;
    end else begin
      p_ack_s1_r <= f_ack_tgl_r;
      p_ack_s2_r <= p_ack_s1_r;
      if (ps_r == PS_WAIT && ack_arrived) begin
        p_ack_seen_r <= p_ack_s2_r;
        // Fabric read data is stable until the next request
        p_rdata_r    <= f_rdata_r;
      end
    end
  end

  // ******************************************************
  // Bridge, fabric clock
  // ******************************************************
  // request toggle into fabric
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      f_req_s1_r   <= 1'b0;
      f_req_s2_r   <= 1'b0;
      f_req_seen_r <= 1'b0;
    end else begin
      f_req_s1_r   <= p_req_tgl_r;
      f_req_s2_r   <= f_req_s1_r;
      f_req_seen_r <= f_req_s2_r;
    end
  end

  assign new_request      = (f_req_s2_r != f_req_seen_r);
  assign reg_word_index   = p_index_r;
  assign reg_write_value  = p_value_r;
  assign reg_byte_lanes   = p_lanes_r;
  assign reg_write_strobe = new_request && p_is_write_r;
  assign reg_read_request = new_request && !p_is_write_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fs_r        <= FS_IDLE;
      f_ack_tgl_r <= 1'b0;
      f_rdata_r   <= RST_WORD;
    end else begin
      unique case (fs_r)
        FS_IDLE: begin
          if (reg_write_strobe) begin
            f_ack_tgl_r <= ~f_ack_tgl_r;
          end else if (reg_read_request) begin
            fs_r <= FS_READ_WAIT;
          end
        end
        FS_READ_WAIT: begin
          if (reg_read_valid) begin
            f_rdata_r   <= reg_read_value;
            f_ack_tgl_r <= ~f_ack_tgl_r;
            fs_r        <= FS_IDLE;
          end
        end
      endcase
    end
  end

  // ******************************************************
  // Register bank, fabric clock
  // ******************************************************
  // decode on strobe; lanes unused; no unmapped write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      file_index_reg_r     <= RST_WORD;
      file_count_reg_r     <= RST_WORD;
      file_size_code_reg_r <= RST_WORD;
      file_timestamp_reg_r <= RST_WORD;
      command_reg_r        <= RST_WORD;
      pattern_choice_reg_r <= RST_WORD;
    end else if (reg_write_strobe) begin
      unique case (reg_word_index)
        IDX_FILE_INDEX: file_index_reg_r     <= reg_write_value;
        IDX_FILE_COUNT: file_count_reg_r     <= reg_write_value;
        IDX_SIZE_CODE:  file_size_code_reg_r <= reg_write_value;
        IDX_TIMESTAMP:  file_timestamp_reg_r <= reg_write_value;
        IDX_COMMAND:    command_reg_r        <= reg_write_value;
        IDX_PATTERN:    pattern_choice_reg_r <= reg_write_value;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_req_r <= 1'b0;
    end else begin
      cmd_req_r <= reg_write_strobe && (reg_word_index == IDX_COMMAND);
    end
  end

  assign target_file_index = file_index_reg_r[FILE_IDX_MSB:0];
  assign file_count        = file_count_reg_r[FILE_CNT_MSB:0];
  assign file_size_code    = file_size_code_reg_r[SIZE_MSB:0];
  assign stamp_seconds     = file_timestamp_reg_r[SEC_MSB:SEC_LSB];
  assign stamp_minutes     = file_timestamp_reg_r[MIN_MSB:MIN_LSB];
  assign stamp_hours       = file_timestamp_reg_r[HOUR_MSB:HOUR_LSB];
  assign stamp_day         = file_timestamp_reg_r[DAY_MSB:DAY_LSB];
  assign stamp_month       = file_timestamp_reg_r[MON_MSB:MON_LSB];
  assign stamp_year        = file_timestamp_reg_r[YEAR_MSB:YEAR_LSB];
  assign command_code      = command_reg_r[CMD_MSB:0];
  assign command_request   = cmd_req_r;
  assign pattern_select    = pattern_choice_reg_r[PATT_MSB:0];

  always_comb begin
    status_word              = RST_WORD;
    status_word[ST_BUSY_BIT] = engine_busy;
    status_word[ST_ERR_BIT]  = engine_error;
    status_word[ST_FAIL_BIT] = verify_fail;
  end

  always_comb begin
    rd_mux = RST_WORD;
    if (reg_word_index == IDX_STATUS) begin
      rd_mux = status_word;
    end
  end

  // pipeline register; index is held, so it is valid at read-valid
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_pipe_r <= RST_WORD;
    end else begin
      rd_pipe_r <= rd_mux;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_dly_r   <= 1'b0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_dly_r   <= reg_read_request;
      rd_valid_r <= rd_dly_r;
    end
  end

  assign reg_read_valid = rd_valid_r;
  assign reg_read_value = rd_pipe_r;

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb_fab @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence seq_status_read;
    reg_read_request && (reg_word_index == IDX_STATUS);
  endsequence
  sequence seq_read_done;
    ##RD_LAT reg_read_valid;
  endsequence
  AST_WR_STROBE_SINGLE: assert property (
    reg_write_strobe |=> !reg_write_strobe)
    else $error("write strobe longer than one cycle");
  AST_RD_LATENCY: assert property (
    reg_read_request |-> !reg_read_valid ##1 !reg_read_valid ##1 reg_read_valid)
    else $error("read valid not two cycles after request");
  AST_INDEX_HOLD: assert property (
    (fs_r == FS_READ_WAIT) && !reg_read_valid |=> $stable(reg_word_index))
    else $error("word index moved during read");
  // Stability window ends on the valid cycle, so the answer is checked there
  AST_STATUS_VALUE: assert property (
    seq_status_read ##0 ($stable(status_word) [*3]) |->
    (reg_read_valid && reg_read_value == status_word))
    else $error("status read returned wrong word");
  AST_UNMAPPED_ZERO: assert property (
    reg_read_request && (reg_word_index != IDX_STATUS) |-> seq_read_done
    ##0 (reg_read_value == RST_WORD))
    else $error("unmapped read not zero");
  AST_CMD_PULSE: assert property (
    reg_write_strobe && (reg_word_index == IDX_COMMAND) |=>
    command_request && (command_code == $past(reg_write_value[CMD_MSB:0])) ##1 !command_request)
    else $error("command write did not pulse request once");
  AST_FULL_WORD: assert property (
    reg_write_strobe && (reg_word_index == IDX_FILE_INDEX) |=>
    file_index_reg_r == $past(reg_write_value))
    else $error("write did not load the full word");
  AST_PATTERN: assert property (
    reg_write_strobe && (reg_word_index == IDX_PATTERN) |=>
    pattern_select == $past(reg_write_value[PATT_MSB:0]))
    else $error("pattern select not loaded");
  AST_BRESP_HOLD: assert property (
    @(posedge processor_clock) disable iff (!nrst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before ready");
  AST_RDATA_HOLD: assert property (
    @(posedge processor_clock) disable iff (!nrst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before ready");

endmodule // crbb_register_subsystem

// File: verif/crbb_engine_model.sv
// Purpose: Behavioural file engine that sits behind the register bank
// Assumes: Runs on the fabric clock; starts come as one-cycle pulses
// Notes:   Flags latch at each start, so status reads stay repeatable
`timescale 1ns/1ns
module crbb_engine_model #(
  parameter int BUSY_CYC = 400  // Busy length in fabric cycles
) (
  input  wire logic       clock,           // Fabric clock
  input  wire logic       nrst,            // Reset, active low
  input  wire logic       command_request, // Start pulse
  input  wire logic       inj_err,         // Raise error at next start
  input  wire logic       inj_fail,        // Raise check failure at next start
  output logic            engine_busy,     // Busy level
  output logic            engine_error,    // Error level
  output logic            verify_fail,     // Check failure level
  output logic [7:0]      req_count        // Starts seen so far
);
  // ******************************************************
  // Engine state
  // ******************************************************
  logic [15:0] busy_cnt_r;

  assign engine_busy = (busy_cnt_r != 16'h0);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_r <= 16'h0;
      req_count  <= 8'h0;
    end else if (command_request) begin
      busy_cnt_r <= 16'(BUSY_CYC);
      req_count  <= req_count + 8'h1;
    end else if (engine_busy) begin
      busy_cnt_r <= busy_cnt_r - 16'h1;
    end
  end

  // Flags stand until the next start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      engine_error <= 1'b0;
      verify_fail  <= 1'b0;
    end else if (command_request) begin
      engine_error <= inj_err;
      verify_fail  <= inj_fail;
    end
  end
endmodule // crbb_engine_model

// File: verif/crbb_register_subsystem_bench.sv
// Purpose: Self-checking bench for the register bridge and bank
// Assumes: One AXI access at a time; engine modelled behaviourally
// Notes:   Writes always use whole words with every byte lane set
`timescale 1ns/1ns
module crbb_register_subsystem_bench;
  import crbb_pkg::*;
  logic              processor_clock = 1'b0, clock = 1'b0, nrst = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb = '0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, command_code;
  logic [15:0]       target_file_index, file_count;
  logic [2:0]        file_size_code, pattern_select;
  logic [4:0]        stamp_seconds, stamp_hours, stamp_day;
  logic [5:0]        stamp_minutes;
  logic [3:0]        stamp_month;
  logic [6:0]        stamp_year;
  logic              command_request, engine_busy, engine_error, verify_fail;
  logic              inj_err = 1'b0, inj_fail = 1'b0;
  logic [7:0]        req_count;
  int                failures = 0, checked = 0, cycles = 0;

  crbb_register_subsystem i_crbb_register_subsystem (
    .processor_clock(processor_clock), .clock(clock), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .target_file_index(target_file_index), .file_count(file_count),
    .file_size_code(file_size_code), .stamp_seconds(stamp_seconds),
    .stamp_minutes(stamp_minutes), .stamp_hours(stamp_hours), .stamp_day(stamp_day),
    .stamp_month(stamp_month), .stamp_year(stamp_year), .command_code(command_code),
    .command_request(command_request), .pattern_select(pattern_select),
    .engine_busy(engine_busy), .engine_error(engine_error), .verify_fail(verify_fail));
  crbb_engine_model i_crbb_engine_model (.clock(clock), .nrst(nrst),
    .command_request(command_request), .inj_err(inj_err), .inj_fail(inj_fail),
    .engine_busy(engine_busy), .engine_error(engine_error),
    .verify_fail(verify_fail), .req_count(req_count));

  always #5 clock = ~clock;
  // Offset start keeps the two clocks out of step
  always begin
    if ($time == 0) #3;
    #80 processor_clock = ~processor_clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up();
    end
  end

  // ******************************************************
  // Shared tasks
  // ******************************************************
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(negedge processor_clock);
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_wstrb = s;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    n = 0;
    do begin @(posedge processor_clock); n++; end while (s_axi_awready !== 1'b1 && n < 40);
    chk({30'h0, s_axi_awready, s_axi_wready}, 32'h3);
    @(negedge processor_clock);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    n = 0;
    do begin @(negedge processor_clock); n++; end while (s_axi_bvalid !== 1'b1 && n < 40);
    // Ready held back a cycle so the response has to stand while it waits
    @(negedge processor_clock);
    s_axi_bready = 1'b1;
    @(posedge processor_clock);
    chk({s_axi_bvalid, 29'h0, s_axi_bresp}, {1'b1, 29'h0, RESP_OKAY});
    @(negedge processor_clock);
    s_axi_bready = 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] exp);
    int n;
    @(negedge processor_clock);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    n = 0;
    do begin @(posedge processor_clock); n++; end while (s_axi_arready !== 1'b1 && n < 40);
    @(negedge processor_clock);
    s_axi_arvalid = 1'b0;
    n = 0;
    do begin @(negedge processor_clock); n++; end while (s_axi_rvalid !== 1'b1 && n < 40);
    @(negedge processor_clock);
    s_axi_rready = 1'b1;
    @(posedge processor_clock);
    chk({s_axi_rvalid, 29'h0, s_axi_rresp}, {1'b1, 29'h0, RESP_OKAY});
    chk(s_axi_rdata, exp);
    @(negedge processor_clock);
    s_axi_rready = 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin @(negedge clock); n++; end while (engine_busy !== 1'b0 && n < 1000);
  endtask

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic t_reset();
    chk({target_file_index, 13'h0, pattern_select}, 32'h0);
    chk({command_request, 29'h0, command_code}, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_regs();
    logic [31:0] ts;
    ts = {7'h55, 4'hA, 5'h13, 5'h0E, 6'h2B, 5'h19};
    axw(OFS_FILE_INDEX, 32'hA5A5_1234, 4'hF);
    chk(32'(target_file_index), 32'h1234);
    axw(OFS_FILE_COUNT, 32'h0000_BEEF, 4'hF);
    chk(32'(file_count), 32'hBEEF);
    axw(OFS_SIZE_CODE, 32'hFFFF_FFF5, 4'hF);
    chk(32'(file_size_code), 32'h5);
    axw(OFS_TIMESTAMP, ts, 4'hF);
    chk({stamp_year, stamp_month, stamp_day, stamp_hours, stamp_minutes, stamp_seconds}, ts);
    $display("register test done");
  endtask

  task automatic t_patt();
    for (int i = 0; i < 5; i++) begin
      axw(OFS_PATTERN, 32'hFFFF_FFF8 | 32'(i), 4'hF);
      chk(32'(pattern_select), 32'(i));
    end
    $display("pattern test done");
  endtask

  task automatic t_cmd();
    logic [7:0] base;
    logic [1:0] codes [3];
    codes = '{2'h0, 2'h2, 2'h3};
    base = req_count;
    for (int i = 0; i < 3; i++) begin
      axw(OFS_COMMAND, {30'h0, codes[i]}, 4'hF);
      chk({req_count, 22'h0, command_code}, {base + 8'(i + 1), 22'h0, codes[i]});
    end
    axw(OFS_PATTERN, 32'h4, 4'hF);
    chk(32'(req_count), 32'(base) + 32'h3);
    $display("command test done");
  endtask

  task automatic t_status();
    wait_idle();
    axr(OFS_STATUS, 32'h0);
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      inj_err = k[0];
      inj_fail = k[1];
      axw(OFS_COMMAND, 32'h3, 4'hF);
      axr(OFS_STATUS, {29'h0, k[1], k[0], 1'b1});
      wait_idle();
      axr(OFS_STATUS, {29'h0, k[1], k[0], 1'b0});
    end
    $display("status test done");
  endtask

  task automatic t_unmapped();
    logic [7:0] base;
    base = req_count;
    axr(OFS_FILE_INDEX, 32'h0);
    axr(12'h200, 32'h0);
    axw(12'h300, 32'hFFFF_FFFF, 4'hF);
    axw(OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
    chk({target_file_index, 13'h0, pattern_select}, {16'h1234, 13'h0, 3'h4});
    chk(32'(req_count), 32'(base));
    $display("unmapped test done");
  endtask

  initial begin
    repeat (2) @(posedge processor_clock);
    @(negedge clock);
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_patt();
    t_cmd();
    t_status();
    t_unmapped();
    wrap_up();
  end
endmodule // crbb_register_subsystem_bench
